// *** bhr_core_model.sv ***
// Behavioural core: presents transfers, debug exceptions, retirements,
// the step flag and the log-full level to the recorder.
// Assumes the testbench calls its tasks and mclk runs free.
`timescale 1ns/1ns
`default_nettype none
module bhr_core_model
(
    // Clock
    input  wire logic   mclk,
    // From the recorder
    input  wire logic   single_step_clear,
    // Transfers
    output logic        br_valid,
    output logic [31:0] br_from,
    output logic [31:0] br_to,
    output logic        ev_valid,
    output logic        ev_fault,
    output logic [31:0] ev_from,
    output logic [31:0] ev_to,
    // Debug, stepping and log state
    output logic        dbg_exc,
    output logic        instr_retired,
    output logic        single_step_flag,
    output logic        log_full
);
    logic step_want;
    int   step_gen    = 0;
    int   cleared_gen = 0;

    // The flag is the level last set by the testbench, until the recorder
    // asks for it to drop; each process owns one of the counters.
    assign single_step_flag = step_want && (cleared_gen != step_gen);

    initial
    begin
        {br_valid, ev_valid, ev_fault, dbg_exc, instr_retired} = 5'h00;
        {step_want, log_full} = 2'h0;
        {br_from, br_to, ev_from, ev_to} = 128'h0;
    end

    // The core drops its own step flag when the recorder asks for it.
    always @(posedge mclk)
    begin
        if (single_step_clear)
            cleared_gen <= step_gen;
    end

    // One transfer cycle; records are given as {to, from}.
    task automatic xfer(input logic b, input logic e, input logic f,
                        input logic [63:0] br_rec, input logic [63:0] ev_rec);
        @(negedge mclk);
        br_valid = b;
        {br_to, br_from} = br_rec;
        ev_valid = e;
        ev_fault = f;
        {ev_to, ev_from} = ev_rec;
        @(negedge mclk);
        {br_valid, ev_valid, ev_fault} = 3'h0;
        // Stale addresses are inverted so that a late sample cannot match.
        {br_to, br_from} = ~{br_to, br_from};
        {ev_to, ev_from} = ~{ev_to, ev_from};
    endtask

    task automatic pulse(input logic dbg, input logic ret);
        @(negedge mclk);
        dbg_exc = dbg;
        instr_retired = ret;
        @(negedge mclk);
        {dbg_exc, instr_retired} = 2'h0;
    endtask

    task automatic levels(input logic s, input logic f);
        @(negedge mclk);
        step_want = s;
        step_gen++;
        log_full = f;
    endtask
endmodule // bhr_core_model
`default_nettype wire

// *** bhr_pkg.sv ***
// Package for the branch history recorder: register indices, control bit
// positions, reset values, record layout and the state types.
// Assumes a 64-bit model-register port and 32-bit linear addresses.
package bhr_pkg;

    localparam int ADDR_W  = 32;
    localparam int REC_W   = 64;
    localparam int DEPTH   = 4;
    localparam int PTR_W   = 2;
    localparam int IDX_W   = 8;
    localparam int CTL_W   = 5;

    // Model register indices.
    localparam logic [IDX_W-1:0] IDX_DEBUG_CONTROL = 8'h00;
    localparam logic [IDX_W-1:0] IDX_ENTRY_BASE    = 8'h10;
    localparam logic [IDX_W-1:0] IDX_HISTORY_TOP   = 8'h14;

    // Debug control bit positions.
    localparam int BIT_HISTORY_ENABLE  = 0;
    localparam int BIT_STEP_ON_BRANCH  = 1;
    localparam int BIT_BUS_MSG_ENABLE  = 2;
    localparam int BIT_MEM_LOG_ENABLE  = 3;
    localparam int BIT_LOG_IRQ_ENABLE  = 4;

    // Record layout: source address low, destination address high.
    localparam int REC_FROM_LSB = 0;
    localparam int REC_TO_LSB   = 32;

    localparam logic [CTL_W-1:0] CTL_RESET  = 5'h00;
    localparam logic [PTR_W-1:0] TOP_RESET  = 2'h0;
    localparam logic [REC_W-1:0] REC_RESET  = 64'h0;

    // Feature query word; only the debug-store availability bit is set.
    localparam int          FEATURE_SAVE_AREA_BIT = 21;
    localparam logic [31:0] FEATURE_FLAGS  = 32'h0020_0000;

    typedef struct packed {
        logic [PTR_W-1:0]            top;
        logic [DEPTH-1:0][REC_W-1:0] entry;
    } bhr_stack_t;

    typedef struct packed {
        logic [CTL_W-1:0] ctl;
        logic [REC_W-1:0] rdata;
        logic             ack;
        logic             fault;
        logic             step;
        logic             ss_clr;
        logic             msg;
        logic             log;
        logic [1:0]       cnt;
        logic [REC_W-1:0] rec_a;
        logic [REC_W-1:0] rec_b;
        logic             irq;
        logic             wrap;
    } bhr_core_t;

endpackage

// *** bhr_recorder.sv ***
// Branch history recorder: debug control register, four-entry history of
// taken branches, interrupts and exceptions, step-on-branch trap request,
// bus trace message and memory log requests.
// Assumes the core presents at most one branch and one interrupt or
// exception per cycle, all on mclk, and that the memory log and bus
// message machinery outside accept the records offered to them.
//
// Function
// - History holds exactly four records, circular.
// - Record every transfer when enabled; wrap, overwrite oldest.
// - Two-bit top pointer marks newest record.
// - Pointer advances before store; 3 wraps to 0.
// - Control bit 0 enables history recording.
// - Record is 64 bits: from and to.
// - Debug exception clears history enable.
// - Control bit 1 makes stepping on transfers.
// - Control bit 2 sends records as bus messages.
// - Control bit 3 logs messages into memory buffer.
// - Bit 4: interrupt when full, else circular.
// - Entries and pointer are read-only, readable.
// - Branch records branch address and target.
// - Interrupt records return pointer and handler.
// - Exception records faulting instruction and handler.
// - Branch with trap: branch record, then exception.
// - Branch with fault: exception record only.
// - Branch then interrupt: branch record, then interrupt.
// - Feature query bit 21 reports debug store.
// - Debug exceptions themselves create no records.
// - Debug exception leaves history entries untouched.
// - Debug exception clears step-on-branch with step flag.
`timescale 1ns/1ns
`default_nettype none
module bhr_recorder
(
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst,
    // Model register port
    input  wire logic [bhr_pkg::IDX_W-1:0]  reg_idx,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic [bhr_pkg::REC_W-1:0]  reg_wdata,
    input  wire logic                       reg_privileged,
    output logic      [bhr_pkg::REC_W-1:0]  reg_rdata,
    output logic                            reg_ack,
    output logic                            reg_fault,
    // Branch taken this cycle
    input  wire logic                       br_valid,
    input  wire logic [bhr_pkg::ADDR_W-1:0] br_from,
    input  wire logic [bhr_pkg::ADDR_W-1:0] br_to,
    // Interrupt or exception taken this cycle
    input  wire logic                       ev_valid,
    input  wire logic                       ev_fault,
    input  wire logic [bhr_pkg::ADDR_W-1:0] ev_from,
    input  wire logic [bhr_pkg::ADDR_W-1:0] ev_to,
    // Debug exception and single stepping
    input  wire logic                       dbg_exc,
    input  wire logic                       instr_retired,
    input  wire logic                       single_step_flag,
    output logic                            step_trap,
    output logic                            single_step_clear,
    // Trace records offered outside
    output logic                            bus_msg_valid,
    output logic                            log_valid,
    output logic      [1:0]                 trace_count,
    output logic      [bhr_pkg::REC_W-1:0]  trace_rec_a,
    output logic      [bhr_pkg::REC_W-1:0]  trace_rec_b,
    input  wire logic                       log_full,
    output logic                            log_full_irq,
    output logic                            log_wrap,
    // Feature query word
    output logic      [31:0]                feature_flags
);

    bhr_pkg::bhr_core_t cur;
    bhr_pkg::bhr_core_t next_cur;

    logic                      hist_en;
    logic                      step_br;
    logic                      br_rec;
    logic                      any_rec;
    logic                      wr_one;
    logic                      wr_two;
    logic [bhr_pkg::REC_W-1:0] br_word;
    logic [bhr_pkg::REC_W-1:0] ev_word;
    logic [bhr_pkg::REC_W-1:0] rec_a;
    logic [bhr_pkg::REC_W-1:0] rec_b;
    logic [bhr_pkg::REC_W-1:0] stack_word;
    logic [bhr_pkg::PTR_W-1:0] top;
    logic                      is_entry;

    assign hist_en = cur.ctl[bhr_pkg::BIT_HISTORY_ENABLE];
    assign step_br = cur.ctl[bhr_pkg::BIT_STEP_ON_BRANCH];

    // A branch that faults is represented only by its exception.
    assign br_rec  = br_valid && !(ev_valid && ev_fault);
    assign any_rec = br_rec || ev_valid;

    // The core supplies the right addresses per kind: branch address and
    // target, saved return pointer and handler, or faulting instruction
    // and handler. The record layout is the same for all of them.
    assign br_word = {br_to, br_from};
    assign ev_word = {ev_to, ev_from};

    // Branch goes first when two transfers arrive together.
    assign rec_a = br_rec ? br_word : ev_word;
    assign rec_b = ev_word;

    // Debug exceptions arrive on their own input and are never recorded,
    // so the stack keeps the last four transfers before one.
    assign wr_two = hist_en && br_rec && ev_valid;
    assign wr_one = hist_en && any_rec && !wr_two;

    assign is_entry = reg_idx[bhr_pkg::IDX_W-1:bhr_pkg::PTR_W] ==
                      bhr_pkg::IDX_ENTRY_BASE[bhr_pkg::IDX_W-1:bhr_pkg::PTR_W];

    bhr_stack u_stack
    (
        .mclk     (mclk),
        .rst      (rst),
        .wr_one   (wr_one),
        .wr_two   (wr_two),
        .rec_a    (rec_a),
        .rec_b    (rec_b),
        .rd_idx   (reg_idx[bhr_pkg::PTR_W-1:0]),
        .rd_entry (stack_word),
        .top      (top)
    );

    always_comb
    begin
        next_cur        = cur;
        next_cur.ack    = 1'b0;
        next_cur.fault  = 1'b0;
        next_cur.step   = 1'b0;
        next_cur.ss_clr = 1'b0;
        next_cur.msg    = 1'b0;
        next_cur.log    = 1'b0;
        next_cur.irq    = 1'b0;
        next_cur.wrap   = 1'b0;

        // Register reads answer one cycle later; unknown indices fault.
        if (reg_rd)
        begin
            next_cur.ack   = 1'b1;
            next_cur.rdata = bhr_pkg::REC_RESET;
            if (reg_idx == bhr_pkg::IDX_DEBUG_CONTROL)
            begin
                next_cur.rdata[bhr_pkg::CTL_W-1:0] = cur.ctl;
            end
            else if (is_entry)
            begin
                next_cur.rdata = stack_word;
            end
            else if (reg_idx == bhr_pkg::IDX_HISTORY_TOP)
            begin
                next_cur.rdata[bhr_pkg::PTR_W-1:0] = top;
            end
            else
            begin
                next_cur.fault = 1'b1;
            end
        end
        else if (reg_wr)
        begin
            next_cur.ack = 1'b1;
            // Writes from unprivileged code are refused rather than
            // trusted, so a misbehaving caller cannot start tracing.
            if (reg_idx == bhr_pkg::IDX_DEBUG_CONTROL && reg_privileged)
            begin
                next_cur.ctl = reg_wdata[bhr_pkg::CTL_W-1:0];
            end
            else
            begin
                next_cur.fault = 1'b1;
            end
        end

        // The exception is taken after any write in the same cycle, so
        // the handler always starts with recording and stepping off.
        if (dbg_exc)
        begin
            next_cur.ctl[bhr_pkg::BIT_HISTORY_ENABLE] = 1'b0;
            next_cur.ctl[bhr_pkg::BIT_STEP_ON_BRANCH] = 1'b0;
            next_cur.ss_clr = 1'b1;
        end

        // Stepping on transfers or on every retired instruction.
        if (single_step_flag && !dbg_exc)
        begin
            next_cur.step = step_br ? any_rec : instr_retired;
        end

        // Trace records leave in the same order as history stores them.
        if (any_rec)
        begin
            next_cur.rec_a = rec_a;
            next_cur.rec_b = rec_b;
            next_cur.cnt   = (br_rec && ev_valid) ? 2'h2 : 2'h1;
            next_cur.msg   = cur.ctl[bhr_pkg::BIT_BUS_MSG_ENABLE];
            if (cur.ctl[bhr_pkg::BIT_MEM_LOG_ENABLE])
            begin
                if (log_full && cur.ctl[bhr_pkg::BIT_LOG_IRQ_ENABLE])
                begin
                    next_cur.irq = 1'b1;
                end
                else
                begin
                    next_cur.log  = 1'b1;
                    next_cur.wrap = log_full;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cur        <= '0;
            cur.ctl    <= bhr_pkg::CTL_RESET;
            cur.rdata  <= bhr_pkg::REC_RESET;
            cur.rec_a  <= bhr_pkg::REC_RESET;
            cur.rec_b  <= bhr_pkg::REC_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign reg_rdata         = cur.rdata;
    assign reg_ack           = cur.ack;
    assign reg_fault         = cur.fault;
    assign step_trap         = cur.step;
    assign single_step_clear = cur.ss_clr;
    assign bus_msg_valid     = cur.msg;
    assign log_valid         = cur.log;
    assign trace_count       = cur.cnt;
    assign trace_rec_a       = cur.rec_a;
    assign trace_rec_b       = cur.rec_b;
    assign log_full_irq      = cur.irq;
    assign log_wrap          = cur.wrap;
    assign feature_flags     = bhr_pkg::FEATURE_FLAGS;

    property p_top_one;
        @(posedge mclk) disable iff (rst)
        wr_one |=> top == $past(top) + 2'h1;
    endproperty
    a_top_one: assert property (p_top_one)
        else $error("Top pointer did not advance by one.");

    property p_top_two;
        @(posedge mclk) disable iff (rst)
        wr_two |=> top == $past(top) + 2'h2;
    endproperty
    a_top_two: assert property (p_top_two)
        else $error("Top pointer did not advance by two.");

    property p_no_rec_off;
        @(posedge mclk) disable iff (rst)
        !hist_en |=> top == $past(top);
    endproperty
    a_no_rec_off: assert property (p_no_rec_off)
        else $error("History changed while recording was off.");

    property p_dbg_clears;
        @(posedge mclk) disable iff (rst)
        dbg_exc |=> !hist_en && !step_br && single_step_clear;
    endproperty
    a_dbg_clears: assert property (p_dbg_clears)
        else $error("Debug exception left recording or stepping on.");

    property p_fault_only;
        @(posedge mclk) disable iff (rst)
        hist_en && br_valid && ev_valid && ev_fault
            |-> wr_one && rec_a == ev_word;
    endproperty
    a_fault_only: assert property (p_fault_only)
        else $error("Faulting branch was recorded.");

    property p_branch_first;
        @(posedge mclk) disable iff (rst)
        hist_en && br_valid && ev_valid && !ev_fault
            |-> wr_two && rec_a == br_word && rec_b == ev_word;
    endproperty
    a_branch_first: assert property (p_branch_first)
        else $error("Branch and event records out of order.");

    property p_step_branch;
        @(posedge mclk) disable iff (rst)
        single_step_flag && step_br && !dbg_exc && !any_rec
            |=> !step_trap;
    endproperty
    a_step_branch: assert property (p_step_branch)
        else $error("Step trap without a control transfer.");

    property p_bus_msg;
        @(posedge mclk) disable iff (rst)
        any_rec && cur.ctl[bhr_pkg::BIT_BUS_MSG_ENABLE]
            |=> bus_msg_valid && trace_rec_a == $past(rec_a);
    endproperty
    a_bus_msg: assert property (p_bus_msg)
        else $error("Bus trace message missing.");

    property p_ro_write;
        @(posedge mclk) disable iff (rst)
        reg_wr && !reg_rd && is_entry |=> reg_fault && reg_ack;
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("Write to history entry was not refused.");

    property p_log_full;
        @(posedge mclk) disable iff (rst)
        any_rec && log_full && cur.ctl[bhr_pkg::BIT_MEM_LOG_ENABLE]
            |=> log_full_irq != log_wrap && log_valid == log_wrap;
    endproperty
    a_log_full: assert property (p_log_full)
        else $error("Full log neither interrupted nor wrapped.");

endmodule // bhr_recorder
`default_nettype wire

// *** bhr_recorder_test.sv ***
// Self-checking testbench for the branch history recorder.
// Assumes the core model drives the transfer side and the tasks here
// speak the model register port, all on falling edges.
`timescale 1ns/1ns
`default_nettype none
module bhr_recorder_test;
    logic mclk, rst, reg_wr, reg_rd, reg_privileged;
    logic [7:0] reg_idx;
    logic [63:0] reg_wdata, reg_rdata, trace_rec_a, trace_rec_b;
    logic reg_ack, reg_fault, br_valid, ev_valid, ev_fault, dbg_exc;
    logic [31:0] br_from, br_to, ev_from, ev_to, feature_flags;
    logic instr_retired, single_step_flag, step_trap, single_step_clear;
    logic bus_msg_valid, log_valid, log_full, log_full_irq, log_wrap;
    logic [1:0] trace_count;
    logic [5:0] pv;
    int pc [6];
    int base [6];
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    bhr_recorder dut (.mclk(mclk), .rst(rst), .reg_idx(reg_idx),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_privileged(reg_privileged), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_fault(reg_fault), .br_valid(br_valid),
        .br_from(br_from), .br_to(br_to), .ev_valid(ev_valid),
        .ev_fault(ev_fault), .ev_from(ev_from), .ev_to(ev_to),
        .dbg_exc(dbg_exc), .instr_retired(instr_retired),
        .single_step_flag(single_step_flag), .step_trap(step_trap),
        .single_step_clear(single_step_clear),
        .bus_msg_valid(bus_msg_valid), .log_valid(log_valid),
        .trace_count(trace_count), .trace_rec_a(trace_rec_a),
        .trace_rec_b(trace_rec_b), .log_full(log_full),
        .log_full_irq(log_full_irq), .log_wrap(log_wrap),
        .feature_flags(feature_flags));

    bhr_core_model core (.mclk(mclk), .single_step_clear(single_step_clear),
        .br_valid(br_valid), .br_from(br_from), .br_to(br_to),
        .ev_valid(ev_valid), .ev_fault(ev_fault), .ev_from(ev_from),
        .ev_to(ev_to), .dbg_exc(dbg_exc), .instr_retired(instr_retired),
        .single_step_flag(single_step_flag), .log_full(log_full));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Pulses are counted rather than caught, so their exact cycle is free.
    assign pv = {step_trap, single_step_clear, bus_msg_valid, log_valid,
                 log_full_irq, log_wrap};
    always @(posedge mclk)
    begin
        for (int i = 0; i < 6; i++)
            pc[i] += int'(pv[i]);
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            close_out();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] idx, input logic [63:0] exp,
                      input logic expf);
        @(negedge mclk);
        reg_idx = idx;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        check({63'h0, reg_ack}, 64'h1);
        check({63'h0, reg_fault}, {63'h0, expf});
        check(reg_rdata, exp);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [63:0] d,
                      input logic priv, input logic expf);
        @(negedge mclk);
        reg_idx = idx;
        reg_wdata = d;
        reg_privileged = priv;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_privileged = 1'b1;
        check({63'h0, reg_ack}, 64'h1);
        check({63'h0, reg_fault}, {63'h0, expf});
    endtask

    task automatic clr();
        @(negedge mclk);
        for (int i = 0; i < 6; i++)
            base[i] = pc[i];
    endtask

    // Digits: step, step clear, bus message, log, log irq, log wrap.
    task automatic pchk(input logic [23:0] exp);
        logic [23:0] s;
        int          d;
        repeat (2) @(negedge mclk);
        for (int i = 0; i < 6; i++)
        begin
            d = pc[i] - base[i];
            s[i*4 +: 4] = d[3:0];
        end
        check({40'h0, s}, {40'h0, exp});
    endtask

    task automatic close_out();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        rst = 1'b1;
        {reg_wr, reg_rd, reg_privileged, reg_idx, reg_wdata} = 75'h0;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        check({63'h0, feature_flags[21]}, 64'h1);
        rd(8'h00, 64'h0, 1'b0);
        rd(8'h14, 64'h0, 1'b0);
        rd(8'h13, 64'h0, 1'b0);
        rd(8'h20, 64'h0, 1'b1);
        wr(8'h00, 64'h01, 1'b0, 1'b1);
        wr(8'h10, 64'h1234, 1'b1, 1'b1);
        rd(8'h10, 64'h0, 1'b0);
        core.xfer(1, 0, 0, 64'h0000_0200_0000_0100, 64'h0);
        rd(8'h14, 64'h0, 1'b0);
        wr(8'h00, 64'h05, 1'b1, 1'b0);
        rd(8'h00, 64'h05, 1'b0);
        clr();
        core.xfer(1, 0, 0, 64'h0000_0200_0000_0100, 64'h0);
        pchk(24'h001000);
        check({62'h0, trace_count}, 64'h1);
        rd(8'h14, 64'h1, 1'b0);
        rd(8'h11, 64'h0000_0200_0000_0100, 1'b0);
        core.xfer(0, 1, 0, 64'h0, 64'h0000_0400_0000_0300);
        core.xfer(0, 1, 1, 64'h0, 64'h0000_0600_0000_0500);
        rd(8'h14, 64'h3, 1'b0);
        rd(8'h12, 64'h0000_0400_0000_0300, 1'b0);
        rd(8'h13, 64'h0000_0600_0000_0500, 1'b0);
        core.xfer(1, 1, 0, 64'h0000_0800_0000_0700, 64'h0000_0a00_0000_0900);
        repeat (2) @(negedge mclk);
        check({62'h0, trace_count}, 64'h2);
        check(trace_rec_a, 64'h0000_0800_0000_0700);
        check(trace_rec_b, 64'h0000_0a00_0000_0900);
        rd(8'h14, 64'h1, 1'b0);
        rd(8'h10, 64'h0000_0800_0000_0700, 1'b0);
        rd(8'h11, 64'h0000_0a00_0000_0900, 1'b0);
        core.xfer(1, 1, 1, 64'h0000_0c00_0000_0b00, 64'h0000_0e00_0000_0d00);
        rd(8'h14, 64'h2, 1'b0);
        rd(8'h12, 64'h0000_0e00_0000_0d00, 1'b0);
        wr(8'h00, 64'h07, 1'b1, 1'b0);
        core.levels(1, 0);
        clr();
        core.pulse(1, 0);
        pchk(24'h010000);
        rd(8'h00, 64'h04, 1'b0);
        rd(8'h14, 64'h2, 1'b0);
        rd(8'h12, 64'h0000_0e00_0000_0d00, 1'b0);
        wr(8'h00, 64'h03, 1'b1, 1'b0);
        core.levels(1, 0);
        clr();
        core.pulse(0, 1);
        pchk(24'h000000);
        clr();
        core.xfer(1, 0, 0, 64'h0000_0f00_0000_0f10, 64'h0);
        pchk(24'h100000);
        wr(8'h00, 64'h01, 1'b1, 1'b0);
        clr();
        core.pulse(0, 1);
        pchk(24'h100000);
        core.levels(0, 0);
        wr(8'h00, 64'h09, 1'b1, 1'b0);
        clr();
        core.xfer(1, 0, 0, 64'h0000_1100_0000_1000, 64'h0);
        pchk(24'h000100);
        core.levels(0, 1);
        wr(8'h00, 64'h19, 1'b1, 1'b0);
        clr();
        core.xfer(1, 0, 0, 64'h0000_1300_0000_1200, 64'h0);
        pchk(24'h000010);
        wr(8'h00, 64'h09, 1'b1, 1'b0);
        clr();
        core.xfer(0, 1, 0, 64'h0, 64'h0000_1500_0000_1400);
        pchk(24'h000101);
        close_out();
    end
endmodule // bhr_recorder_test
`default_nettype wire

// *** bhr_stack.sv ***
// Four-entry circular history stack with its top pointer.
// Assumes the caller asks for at most two pushes per cycle, oldest first.
`timescale 1ns/1ns
`default_nettype none
module bhr_stack
(
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // Push requests
    input  wire logic                      wr_one,
    input  wire logic                      wr_two,
    input  wire logic [bhr_pkg::REC_W-1:0] rec_a,
    input  wire logic [bhr_pkg::REC_W-1:0] rec_b,
    // Read side
    input  wire logic [bhr_pkg::PTR_W-1:0] rd_idx,
    output logic      [bhr_pkg::REC_W-1:0] rd_entry,
    output logic      [bhr_pkg::PTR_W-1:0] top
);

    bhr_pkg::bhr_stack_t cur;
    bhr_pkg::bhr_stack_t next_cur;

    always_comb
    begin
        next_cur = cur;
        // The pointer advances before each store and wraps from 3 to 0.
        if (wr_two)
        begin
            next_cur.entry[cur.top + 2'h1] = rec_a;
            next_cur.entry[cur.top + 2'h2] = rec_b;
            next_cur.top = cur.top + 2'h2;
        end
        else if (wr_one)
        begin
            next_cur.entry[cur.top + 2'h1] = rec_a;
            next_cur.top = cur.top + 2'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cur.top <= bhr_pkg::TOP_RESET;
            for (int i = 0; i < bhr_pkg::DEPTH; i++)
            begin
                cur.entry[i] <= bhr_pkg::REC_RESET;
            end
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign rd_entry = cur.entry[rd_idx];
    assign top      = cur.top;

    property p_newest_at_top;
        @(posedge mclk) disable iff (rst)
        wr_one && !wr_two |=> cur.entry[cur.top] == $past(rec_a);
    endproperty
    a_newest_at_top: assert property (p_newest_at_top)
        else $error("Newest record is not at the top entry.");

endmodule // bhr_stack
`default_nettype wire
